// file: shared/dpf_pkg.sv
package dpf_pkg;

  localparam int DATA_W = 8;
  localparam int ADDR_W = 4;
  localparam int PIN_N = 8;

  // Register addresses on the host bus.
  localparam logic [ADDR_W-1:0] ADDR_OUT_CFG = 4'hd;
  localparam logic [ADDR_W-1:0] ADDR_OUT_PORT = 4'he;

  // Reset values.
  localparam logic [DATA_W-1:0] OUT_PORT_RST = 8'h00;
  localparam logic [DATA_W-1:0] OUT_CFG_RST = 8'h00;

  // Output pin indices.
  localparam int PIN_RTS_B = 1;
  localparam int PIN_CLK_B = 3;
  localparam int PIN_RXRDY_B = 5;
  localparam int PIN_CHAN_A_TX_READY_N = 6;
  localparam int PIN_CHAN_B_TX_READY_N = 7;

  // Fields of the output configuration register.
  localparam int CFG_SEL3_LO = 2;
  localparam int CFG_SEL3_HI = 3;
  localparam int CFG_RXRDY_B = 5;
  localparam int CFG_CHAN_A_TX_READY_N = 6;
  localparam int CFG_CHAN_B_TX_READY_N = 7;

  typedef enum logic [1:0] {
    SEL3_GP = 2'b00,
    SEL3_CT_READY = 2'b01,
    SEL3_TX_CLK = 2'b10,
    SEL3_RX_CLK = 2'b11
  } dpf_sel3_e;

  // Alternate-function sources from the rest of the device.
  typedef struct packed {
    logic chanBRequestToSendN;
    logic chanBTxUnityClockOut;
    logic chanBRxUnityClockOut;
    logic counterReady;
    logic chanBRxReadyOrFull;
    logic chanATxReady;
    logic chanBTxReady;
  } dpf_alt_s;

  // Driven pins: level and enable, one bit per pin.
  typedef struct packed {
    logic [PIN_N-1:0] level;
    logic [PIN_N-1:0] enable;
  } dpf_pins_s;

endpackage

// file: hw/dpf_pin_cell.sv
// Chooses between the general-purpose level and an alternate function.
// An open-drain alternate pulls low while active and floats otherwise.
module dpf_pin_cell (
  // Selection
  input wire logic altSelect,
  input wire logic altOpenDrain,
  // Values
  input wire logic gpBit,
  input wire logic altValue,
  // Pin drive
  output logic pinLevel,
  output logic pinEnable
);

  always_comb begin
    if (!altSelect) begin
      pinLevel = ~gpBit;
      pinEnable = 1'b1;
    end else if (altOpenDrain) begin
      pinLevel = 1'b0;
      pinEnable = altValue;
    end else begin
      pinLevel = altValue;
      pinEnable = 1'b1;
    end
  end

endmodule

// file: hw/dpf_pin_functions.sv
// How it works
// (R01) Config can put channel B request-to-send, active low, on output bit 1.
// (R02) Output bit 3 carries B transmit clock, B receive clock or timer ready.
// (R03) Output bit 5 can pull low for channel B receiver ready or FIFO full.
// (R04) Output bit 7 can pull low while channel B transmitter is ready.
// (R05) Output bit 6 can pull low while channel A transmitter is ready.
// (R06) Host transfers use one 8-bit bus, bit 7 most significant.
// (R07) Bus floats when chip select is high, except Z-mode acknowledge.
// (R08) Interrupt pin is open drain, low while any enabled condition stands.
// (R09) Interrupt stays low until the host clears every causing condition.
// (R10) Reset clears output port and config registers; all outputs go high.
// (R11) Host writes with select and strobe low; capture on strobe rise.
// (R12) Pins without alternate function drive the inverse of the general-purpose bit.
module dpf_pin_functions (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Host bus
  input wire logic chipSelectN,
  input wire logic writeStrobeN,
  input wire logic readStrobeN,
  input wire logic [dpf_pkg::ADDR_W-1:0] address,
  input wire logic [dpf_pkg::DATA_W-1:0] hostDataBusIn,
  output logic [dpf_pkg::DATA_W-1:0] hostDataBusOut,
  output logic hostDataBusOe,
  // Acknowledge cycle
  input wire logic zMode,
  input wire logic interruptAcknowledgeCycle,
  input wire logic [dpf_pkg::DATA_W-1:0] interruptVector,
  // Read data from the addressed device register
  input wire logic [dpf_pkg::DATA_W-1:0] registerReadData,
  // Configuration and sources
  input wire logic rtsBEnable,
  input wire dpf_pkg::dpf_alt_s altSources,
  // Interrupt conditions
  input wire logic [dpf_pkg::DATA_W-1:0] interruptStatus,
  input wire logic [dpf_pkg::DATA_W-1:0] interruptMask,
  output logic interruptRequestOutN,
  output logic interruptRequestOe,
  // Output pins
  output logic [dpf_pkg::PIN_N-1:0] outputPinLevel,
  output logic [dpf_pkg::PIN_N-1:0] outputPinOe,
  // Register view
  output logic [dpf_pkg::DATA_W-1:0] outputPortRegOut,
  output logic [dpf_pkg::DATA_W-1:0] outputPortConfigRegOut
);
  import dpf_pkg::*;

  typedef struct packed {
    logic [DATA_W-1:0] outputPort;
    logic [DATA_W-1:0] outputPortConfig;
    logic strobeWasLow;
    logic [ADDR_W-1:0] addrHeld;
    logic [DATA_W-1:0] dataHeld;
    dpf_pins_s pins;
    logic [DATA_W-1:0] busOut;
    logic busOe;
    logic irqOe;
  } dpf_state_s;

  dpf_state_s state_reg;
  dpf_state_s state_next;

  logic [PIN_N-1:0] altSelect;
  logic [PIN_N-1:0] altOpenDrain;
  logic [PIN_N-1:0] altValue;
  logic [PIN_N-1:0] cellLevel;
  logic [PIN_N-1:0] cellEnable;
  dpf_sel3_e sel3;

  function automatic logic hostAccess(input logic csN, input logic strobeN);
    hostAccess = !csN && !strobeN;
  endfunction

  assign sel3 = dpf_sel3_e'(
    state_reg.outputPortConfig[CFG_SEL3_HI:CFG_SEL3_LO]);

  always_comb begin
    altSelect = '0;
    altOpenDrain = '0;
    altValue = '0;
    altSelect[PIN_RTS_B] = rtsBEnable; // [R01]
    altValue[PIN_RTS_B] = altSources.chanBRequestToSendN; // [R01]
    altSelect[PIN_CLK_B] = (sel3 != SEL3_GP); // [R02]
    case (sel3)
      SEL3_CT_READY: begin
        altOpenDrain[PIN_CLK_B] = 1'b1; // [R02]
        altValue[PIN_CLK_B] = altSources.counterReady;
      end
      SEL3_TX_CLK: altValue[PIN_CLK_B] = altSources.chanBTxUnityClockOut;
      SEL3_RX_CLK: altValue[PIN_CLK_B] = altSources.chanBRxUnityClockOut;
      default: altValue[PIN_CLK_B] = 1'b0;
    endcase
    altSelect[PIN_RXRDY_B] = state_reg.outputPortConfig[CFG_RXRDY_B]; // [R03]
    altOpenDrain[PIN_RXRDY_B] = 1'b1;
    altValue[PIN_RXRDY_B] = altSources.chanBRxReadyOrFull;
    altSelect[PIN_CHAN_A_TX_READY_N] = state_reg.outputPortConfig[CFG_CHAN_A_TX_READY_N]; // [R05]
    altOpenDrain[PIN_CHAN_A_TX_READY_N] = 1'b1;
    altValue[PIN_CHAN_A_TX_READY_N] = altSources.chanATxReady;
    altSelect[PIN_CHAN_B_TX_READY_N] = state_reg.outputPortConfig[CFG_CHAN_B_TX_READY_N]; // [R04]
    altOpenDrain[PIN_CHAN_B_TX_READY_N] = 1'b1;
    altValue[PIN_CHAN_B_TX_READY_N] = altSources.chanBTxReady;
  end

  for (genvar i = 0; i < PIN_N; i++) begin : gPin
    dpf_pin_cell uCell (
      .altSelect(altSelect[i]),
      .altOpenDrain(altOpenDrain[i]),
      .gpBit(state_reg.outputPort[i]), // [R12]
      .altValue(altValue[i]),
      .pinLevel(cellLevel[i]),
      .pinEnable(cellEnable[i])
    );
  end

  always_comb begin
    state_next = state_reg;
    state_next.strobeWasLow = hostAccess(chipSelectN, writeStrobeN);
    if (hostAccess(chipSelectN, writeStrobeN)) begin
      state_next.addrHeld = address;
      state_next.dataHeld = hostDataBusIn;
    end
    // Commit on the rising edge of the write strobe.
    if (state_reg.strobeWasLow && writeStrobeN) begin // [R11]
      case (state_reg.addrHeld)
        ADDR_OUT_PORT: state_next.outputPort = state_reg.dataHeld;
        ADDR_OUT_CFG: state_next.outputPortConfig = state_reg.dataHeld;
        default: state_next.outputPort = state_reg.outputPort;
      endcase
    end
    state_next.pins.level = cellLevel;
    state_next.pins.enable = cellEnable;
    state_next.busOe = hostAccess(chipSelectN, readStrobeN)
      || (zMode && interruptAcknowledgeCycle); // [R07]
    if (zMode && interruptAcknowledgeCycle) begin
      state_next.busOut = interruptVector;
    end else begin
      state_next.busOut = registerReadData; // [R06]
    end
    state_next.irqOe = |(interruptStatus & interruptMask); // [R08] [R09]
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg.outputPort <= OUT_PORT_RST; // [R10]
      state_reg.outputPortConfig <= OUT_CFG_RST; // [R10]
      state_reg.strobeWasLow <= 1'b0;
      state_reg.addrHeld <= '0;
      state_reg.dataHeld <= '0;
      state_reg.pins.level <= '1; // [R10]
      state_reg.pins.enable <= '1;
      state_reg.busOut <= '0;
      state_reg.busOe <= 1'b0;
      state_reg.irqOe <= 1'b0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign outputPinLevel = state_reg.pins.level;
  assign outputPinOe = state_reg.pins.enable;
  assign hostDataBusOut = state_reg.busOut;
  assign hostDataBusOe = state_reg.busOe;
  assign interruptRequestOutN = 1'b0;
  assign interruptRequestOe = state_reg.irqOe;
  assign outputPortRegOut = state_reg.outputPort;
  assign outputPortConfigRegOut = state_reg.outputPortConfig;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence sWriteLow;
    hostAccess(chipSelectN, writeStrobeN) && address == ADDR_OUT_PORT;
  endsequence
  sequence sStrobeRise;
    writeStrobeN;
  endsequence

  a_write_port_commit: assert property ( // [R11]
    sWriteLow ##1 sStrobeRise
    |-> ##1 outputPortRegOut == $past(hostDataBusIn, 2))
    else $error("output port write not captured on strobe rise");
  a_no_write_hold: assert property ( // [R11]
    !state_reg.strobeWasLow |=> $stable(outputPortRegOut))
    else $error("output port changed without a write");
  a_bus_float: assert property ( // [R07]
    (chipSelectN && !(zMode && interruptAcknowledgeCycle)) |=> !hostDataBusOe)
    else $error("data bus driven while deselected");
  a_interrupt_acknowledge_cycle_drive: assert property ( // [R07]
    (zMode && interruptAcknowledgeCycle) |=>
      hostDataBusOe && hostDataBusOut == $past(interruptVector))
    else $error("vector not driven in acknowledge cycle");
  a_read_data: assert property ( // [R06]
    (hostAccess(chipSelectN, readStrobeN) && !interruptAcknowledgeCycle) |=>
      hostDataBusOe && hostDataBusOut == $past(registerReadData))
    else $error("read data not on bus");
  a_irq_level: assert property ( // [R08]
    |(interruptStatus & interruptMask) |=> interruptRequestOe)
    else $error("interrupt not asserted for enabled condition");
  a_irq_release: assert property ( // [R09]
    (interruptStatus & interruptMask) == '0 |=> !interruptRequestOe)
    else $error("interrupt held after conditions cleared");
  a_gp_follow: assert property ( // [R12]
    (outputPortConfigRegOut == '0 && !rtsBEnable) [*2] |->
      outputPinLevel == ~$past(outputPortRegOut) && outputPinOe == '1)
    else $error("general-purpose pin does not follow register");
  a_rts_pin: assert property ( // [R01]
    rtsBEnable |=> outputPinLevel[PIN_RTS_B] ==
      $past(altSources.chanBRequestToSendN))
    else $error("request-to-send not on bit 1");
  a_chan_a_tx_ready_n_od: assert property ( // [R05]
    state_reg.outputPortConfig[CFG_CHAN_A_TX_READY_N] |=>
      !outputPinLevel[PIN_CHAN_A_TX_READY_N]
      && outputPinOe[PIN_CHAN_A_TX_READY_N] == $past(altSources.chanATxReady))
    else $error("channel A ready pin not open drain");
  a_chan_b_tx_ready_n_od: assert property ( // [R04]
    state_reg.outputPortConfig[CFG_CHAN_B_TX_READY_N] |=>
      outputPinOe[PIN_CHAN_B_TX_READY_N] == $past(altSources.chanBTxReady))
    else $error("channel B ready pin wrong");
  a_rxrdy_b_od: assert property ( // [R03]
    state_reg.outputPortConfig[CFG_RXRDY_B] |=>
      outputPinOe[PIN_RXRDY_B] == $past(altSources.chanBRxReadyOrFull))
    else $error("channel B receive ready pin wrong");
  a_ct_ready: assert property ( // [R02]
    sel3 == SEL3_CT_READY |=> !outputPinLevel[PIN_CLK_B]
      && outputPinOe[PIN_CLK_B] == $past(altSources.counterReady))
    else $error("timer ready pin wrong");
  a_reset_high: assert property ( // [R10]
    $rose(rst_n) |-> outputPinLevel == '1 && outputPortRegOut == '0)
    else $error("outputs not high after reset");

endmodule

// file: verif/dpf_host_model.sv
// Host processor on the parallel bus, with write, read and acknowledge cycles.
module dpf_host_model (
  // Clock
  input wire logic ref_clk,
  // Bus control
  output logic chipSelectN,
  output logic writeStrobeN,
  output logic readStrobeN,
  output logic [dpf_pkg::ADDR_W-1:0] address,
  output logic zMode,
  output logic ackCycle,
  // Data
  output logic [dpf_pkg::DATA_W-1:0] hostData,
  input wire logic [dpf_pkg::DATA_W-1:0] busOut,
  input wire logic busOe
);
  timeunit 1ns;
  timeprecision 1ns;
  import dpf_pkg::*;
  logic [DATA_W-1:0] readData;
  logic readOe;
  initial begin
    {chipSelectN, writeStrobeN, readStrobeN} = 3'b111;
    {zMode, ackCycle} = 2'b00;
    address = '0;
    hostData = '0;
  end
  task automatic writeReg(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    chipSelectN <= 1'b0;
    writeStrobeN <= 1'b0;
    address <= a;
    hostData <= d;
    @(posedge ref_clk);
    writeStrobeN <= 1'b1;
    @(posedge ref_clk);
    chipSelectN <= 1'b1;
    // A released bus shows the inverse rather than a stale value.
    hostData <= ~d;
  endtask
  task automatic readReg(input logic [ADDR_W-1:0] a, input logic viaAck,
                         input logic z);
    @(posedge ref_clk);
    address <= a;
    zMode <= z;
    if (viaAck) begin
      ackCycle <= 1'b1;
    end else begin
      chipSelectN <= 1'b0;
      readStrobeN <= 1'b0;
    end
    @(posedge ref_clk);
    @(negedge ref_clk);
    readData = busOut;
    readOe = busOe;
    @(posedge ref_clk);
    {chipSelectN, readStrobeN, ackCycle, zMode} <= 4'b1100;
  endtask
endmodule

// file: verif/dpf_pin_functions_tb_top.sv
module dpf_pin_functions_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import dpf_pkg::*;
  logic ref_clk, rst_n, rtsBEnable, busOe, irqN, irqOe, csN, wrN, rdN, zm, ack;
  dpf_alt_s altSources;
  logic [7:0] busIn, busOut, hostData, rdData, vec, irqStat, irqMask;
  logic [7:0] portReg, cfgReg, pinLvl, pinOe;
  logic [ADDR_W-1:0] addr;
  logic [16:0] irqTbl [4];
  int failCount, nCompared;
  assign busIn = busOe ? busOut : hostData;
  dpf_host_model host (.ref_clk(ref_clk), .chipSelectN(csN),
    .writeStrobeN(wrN), .readStrobeN(rdN), .address(addr), .zMode(zm),
    .ackCycle(ack), .hostData(hostData), .busOut(busOut), .busOe(busOe));
  dpf_pin_functions DUT (.ref_clk(ref_clk), .rst_n(rst_n),
    .chipSelectN(csN), .writeStrobeN(wrN), .readStrobeN(rdN),
    .address(addr), .hostDataBusIn(busIn), .hostDataBusOut(busOut),
    .hostDataBusOe(busOe), .zMode(zm), .interruptAcknowledgeCycle(ack),
    .interruptVector(vec), .registerReadData(rdData),
    .rtsBEnable(rtsBEnable), .altSources(altSources),
    .interruptStatus(irqStat), .interruptMask(irqMask),
    .interruptRequestOutN(irqN), .interruptRequestOe(irqOe),
    .outputPinLevel(pinLvl), .outputPinOe(pinOe),
    .outputPortRegOut(portReg), .outputPortConfigRegOut(cfgReg));
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    nCompared++;
    if (seen !== exp) begin
      failCount++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic settle;
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask
  task automatic end_of_test;
    $display("compared %0d, mismatches %0d", nCompared, failCount);
    if (failCount == 0 && nCompared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge ref_clk);
    failCount++;
    end_of_test();
  end
  initial begin
    rst_n = 1'b0;
    rtsBEnable = 1'b0;
    altSources = '0;
    {irqStat, irqMask, rdData, vec} = '0;
    irqTbl = '{{16'h0c00, 1'b0}, {16'h0c0c, 1'b1}, {16'h080c, 1'b1},
               {16'h000c, 1'b0}};
    repeat (4) @(posedge ref_clk);
    @(negedge ref_clk);
    chk({pinLvl, pinOe}, 16'hffff);
    chk({portReg, cfgReg}, 16'h0000);
    chk({busOe, irqOe}, 16'h0000);
    @(posedge ref_clk);
    rst_n <= 1'b1;
    host.writeReg(ADDR_OUT_PORT, 8'ha5);
    settle();
    chk({portReg, pinLvl, pinOe}, {8'ha5, 8'h5a, 8'hff});
    host.writeReg(4'h3, 8'hff);
    settle();
    chk({portReg, cfgReg}, {8'ha5, 8'h00});
    @(posedge ref_clk);
    rtsBEnable <= 1'b1;
    altSources.chanBRequestToSendN <= 1'b1;
    settle();
    chk({pinLvl[1], pinOe[1]}, 2'b11);
    @(posedge ref_clk);
    altSources.chanBRequestToSendN <= 1'b0;
    settle();
    chk({pinLvl[1], pinOe[1]}, 2'b01);
    @(posedge ref_clk);
    rtsBEnable <= 1'b0;
    settle();
    chk(pinLvl[1], 1'b1);
    for (int s = 0; s < 4; s++) begin
      host.writeReg(ADDR_OUT_CFG, {4'h0, s[1:0], 2'b00});
      for (int v = 0; v < 2; v++) begin
        @(posedge ref_clk);
        altSources.chanBTxUnityClockOut <= v[0];
        altSources.chanBRxUnityClockOut <= ~v[0];
        altSources.counterReady <= v[0];
        settle();
        chk({pinLvl[3], pinOe[3]}, (s == 0) ? 2'b11 : (s == 1) ? {1'b0, v[0]}
            : (s == 2) ? {v[0], 1'b1} : {~v[0], 1'b1});
      end
    end
    host.writeReg(ADDR_OUT_CFG, 8'he0);
    for (int v = 0; v < 2; v++) begin
      @(posedge ref_clk);
      altSources.chanBRxReadyOrFull <= v[0];
      altSources.chanATxReady <= ~v[0];
      altSources.chanBTxReady <= v[0];
      settle();
      chk({pinLvl[7:5], pinOe[7:5]},
          {3'b000, v[0], ~v[0], v[0]});
    end
    @(posedge ref_clk);
    rdData <= 8'h3c;
    vec <= 8'h96;
    host.readReg(ADDR_OUT_PORT, 1'b0, 1'b0);
    chk({host.readOe, host.readData}, {1'b1, 8'h3c});
    settle();
    chk(busOe, 1'b0);
    for (int z = 0; z < 2; z++) begin
      host.readReg(ADDR_OUT_PORT, 1'b1, z[0]);
      chk(host.readOe, z[0]);
      if (z == 1) chk(host.readData, 8'h96);
    end
    for (int i = 0; i < 4; i++) begin
      @(posedge ref_clk);
      {irqStat, irqMask} <= irqTbl[i][16:1];
      settle();
      chk({irqOe, irqN}, {irqTbl[i][0], 1'b0});
    end
    @(posedge ref_clk);
    rst_n <= 1'b0;
    @(negedge ref_clk);
    chk({portReg, cfgReg, pinLvl, pinOe}, 32'h0000ffff);
    end_of_test();
  end
endmodule
